// ---- core/tlic_arb.sv ----
module tlic_arb
  import tlic_pkg::*;
(
  // Candidates in, winner out
  tlic_arb_if.arb bus
);

  // ==========================================================
  // Lowest set index of a mask
  function automatic tlic_idx_t first_set(input logic [11:0] mask);
    first_set = 4'h0;
    for (int i = int'(TLIC_NSRC) - 1; i >= 0; i--) begin
      if (mask[i]) begin
        first_set = tlic_idx_t'(i);
      end
    end
  endfunction : first_set

  logic [11:0] hi_mask;

  // ==========================================================
  // High level beats low; within a level, lower number wins
  always_comb begin
    hi_mask   = bus.cand & bus.prio_hi;
    bus.valid = |bus.cand;
    bus.high  = |hi_mask;
    if (|hi_mask) begin
      bus.idx = first_set(hi_mask);
    end else begin
      bus.idx = first_set(bus.cand);
    end
  end

endmodule : tlic_arb

// ---- core/tlic_arb_if.sv ----
interface tlic_arb_if;
  import tlic_pkg::*;

  logic [11:0] cand;
  logic [11:0] prio_hi;
  logic        valid;
  tlic_idx_t   idx;
  logic        high;

  modport ctrl (output cand, output prio_hi, input valid, input idx, input high);
  modport arb  (input cand, input prio_hi, output valid, output idx, output high);
endinterface : tlic_arb_if

// ---- core/tlic_pkg.sv ----
package tlic_pkg;

  // ==========================================================
  // Sizes and register map
  localparam int unsigned  TLIC_NSRC        = 12;
  localparam logic [7:0]   TLIC_IE_ADDR     = 8'hA8;
  // Bit addresses 0xA8..0xAF hit the enable register
  localparam logic [4:0]   TLIC_IE_BIT_BASE = 5'h15;
  localparam logic [7:0]   TLIC_IE_RESET    = 8'h00;
  localparam logic [7:0]   TLIC_RD_UNMAPPED = 8'h00;

  // ==========================================================
  // Enable register fields
  localparam int unsigned  TLIC_GATE_BIT    = 7;
  localparam int unsigned  TLIC_SPARE_BIT   = 6;
  localparam int unsigned  TLIC_TMR2_BIT    = 5;
  localparam int unsigned  TLIC_SER_BIT     = 4;
  localparam int unsigned  TLIC_TMR1_BIT    = 3;
  localparam int unsigned  TLIC_EXT1_BIT    = 2;
  localparam int unsigned  TLIC_TMR0_BIT    = 1;
  localparam int unsigned  TLIC_EXT0_BIT    = 0;

  // ==========================================================
  // Source numbers, also the arbitration order within a priority level (low wins)
  localparam int unsigned  TLIC_SRC_EXT0    = 0;
  localparam int unsigned  TLIC_SRC_TMR0    = 1;
  localparam int unsigned  TLIC_SRC_EXT1    = 2;
  localparam int unsigned  TLIC_SRC_TMR1    = 3;
  localparam int unsigned  TLIC_SRC_SER     = 4;
  localparam int unsigned  TLIC_SRC_TMR2    = 5;
  localparam int unsigned  TLIC_SRC_AUX     = 6;
  localparam int unsigned  TLIC_NAUX        = 6;

  // Flags cleared by hardware on handler entry
  localparam logic [11:0]  TLIC_AUTO_CLR    = 12'h00F;
  localparam logic [11:0]  TLIC_PEND_RESET  = 12'h000;
  // Pins idle high
  localparam logic [1:0]   TLIC_PIN_IDLE    = 2'h3;

  // ==========================================================
  // Handler addresses
  localparam logic [15:0]  TLIC_VEC_BASE    = 16'h0003;
  localparam int unsigned  TLIC_VEC_SHIFT   = 3;

  typedef logic [3:0] tlic_idx_t;

  function automatic logic [15:0] tlic_vector(input tlic_idx_t idx);
    tlic_vector = TLIC_VEC_BASE + ({12'h000, idx} << TLIC_VEC_SHIFT);
  endfunction : tlic_vector

  // ==========================================================
  // Controller state
  typedef struct packed {
    logic [7:0]  ie;
    logic [11:0] pend;
    logic [1:0]  pin_s1;
    logic [1:0]  pin_s2;
    logic [1:0]  pin_prev;
    logic        req;
    tlic_idx_t   req_idx;
    logic        req_high;
    logic        long_subroutine_call_go;
    logic [15:0] vector;
    tlic_idx_t   svc_idx;
    logic        in_svc_lo;
    logic        in_svc_hi;
    logic [7:0]  rdata;
  } tlic_state_t;

endpackage : tlic_pkg

// ---- core/tlic_top.sv ----
// Notes on behaviour
// - Twelve sources, arbitrated over two priority levels.
// - A source event sets its pending flag even when the source is disabled.
// - Enabled pending source forces a call to its handler after current instruction.
// - Handler ends with return instruction; execution resumes where it left off.
// - Disabled source's pending flag is ignored; no request raised.
// - Per-source enables only count while the global gate bit 7 is set.
// - Request seen during enable clear may be taken if next instruction is single-cycle.
// - Inside such a late handler the cleared enable bit reads zero.
// - Some flags clear on handler entry; the rest software clears.
// - Flag still set after return re-requests, re-entering after one more instruction.
// - Eight-bit enable register at 0xA8, bit addressable, resets to zero.
// - Gate bit 7 at one enables sources by mask; at zero none.
// - Bit 6 is a plain storage bit with no effect.
// - Bit 5 enables the timer-two source from either overflow flag.
// - Bit 4 enables the serial port source.
// - Bit 3 enables the timer-one overflow source.
// - Bit 2 enables the external line one source.
// - Bit 1 enables the timer-zero overflow source.
// - Bit 0 enables the external line zero source.
module tlic_top
  import tlic_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Special function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // Single bit access
  input  wire logic [7:0]  sfr_bit_addr,
  input  wire logic        sfr_bit_wr,
  input  wire logic        sfr_bit_val,
  // Event sources
  input  wire logic        ext_line_zero_pin,
  input  wire logic        ext_line_one_pin,
  input  wire logic        tmr_zero_overflow,
  input  wire logic        tmr_one_overflow,
  input  wire logic        tmr_two_low_overflow,
  input  wire logic        tmr_two_high_overflow,
  input  wire logic        serial_port_event,
  input  wire logic [5:0]  aux_event,
  // Settings held outside this block
  input  wire logic [5:0]  aux_enable,
  input  wire logic [11:0] src_prio_high,
  // Software clear of pending flags
  input  wire logic [11:0] pend_clr,
  // Processor core sequencing
  input  wire logic        cpu_instr_done,
  input  wire logic        cpu_return_from_handler_done,
  output logic             irq_req,
  output logic             long_subroutine_call,
  output logic      [15:0] service_handler_addr,
  output logic      [11:0] pend_flags,
  output logic      [7:0]  interrupt_enable_mask
);

  tlic_state_t st;
  tlic_state_t next_st;

  logic [11:0] src_event;
  logic [11:0] src_enable;
  logic [11:0] allowed;
  logic [11:0] set_mask;
  logic [11:0] clr_mask;
  logic [1:0]  pin_fall;
  logic        take;

  tlic_arb_if arb_bus ();

  tlic_arb u_arb (
    .bus (arb_bus.arb)
  );

  // ==========================================================
  // Pin edges and source events
  always_comb begin
    // Pins are active low; only the second synchroniser stage is looked at
    pin_fall = st.pin_prev & ~st.pin_s2;
    src_event                = '0;
    src_event[TLIC_SRC_EXT0] = pin_fall[0];
    src_event[TLIC_SRC_TMR0] = tmr_zero_overflow;
    src_event[TLIC_SRC_EXT1] = pin_fall[1];
    src_event[TLIC_SRC_TMR1] = tmr_one_overflow;
    src_event[TLIC_SRC_SER]  = serial_port_event;
    src_event[TLIC_SRC_TMR2] = tmr_two_low_overflow | tmr_two_high_overflow;
    src_event[TLIC_SRC_AUX +: TLIC_NAUX] = aux_event;
  end

  // ==========================================================
  // Enables, gate and service blocking
  always_comb begin
    src_enable                = '0;
    src_enable[TLIC_SRC_EXT0] = st.ie[TLIC_EXT0_BIT];
    src_enable[TLIC_SRC_TMR0] = st.ie[TLIC_TMR0_BIT];
    src_enable[TLIC_SRC_EXT1] = st.ie[TLIC_EXT1_BIT];
    src_enable[TLIC_SRC_TMR1] = st.ie[TLIC_TMR1_BIT];
    src_enable[TLIC_SRC_SER]  = st.ie[TLIC_SER_BIT];
    src_enable[TLIC_SRC_TMR2] = st.ie[TLIC_TMR2_BIT];
    src_enable[TLIC_SRC_AUX +: TLIC_NAUX] = aux_enable;
    // Spare bit 6 is deliberately absent here
    if (!st.ie[TLIC_GATE_BIT]) begin
      src_enable = '0;
    end
    if (st.in_svc_hi) begin
      allowed = '0;
    end else if (st.in_svc_lo) begin
      allowed = src_prio_high;
    end else begin
      allowed = '1;
    end
    arb_bus.cand    = st.pend & src_enable & allowed;
    arb_bus.prio_hi = src_prio_high;
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st          = st;
    next_st.long_subroutine_call_go = 1'b0;

    // Synchronise the pins
    next_st.pin_s1   = {ext_line_one_pin, ext_line_zero_pin};
    next_st.pin_s2   = st.pin_s1;
    next_st.pin_prev = st.pin_s2;

    // Request is registered, so an enable clear reaches it one cycle late;
    // a single-cycle instruction after the clear can still be vectored.
    next_st.req      = arb_bus.valid;
    next_st.req_idx  = arb_bus.idx;
    next_st.req_high = arb_bus.high;

    // Vector on an instruction boundary; never on the return itself, so a
    // flag left set re-enters only after one more instruction
    take     = cpu_instr_done & ~cpu_return_from_handler_done & st.req;
    clr_mask = pend_clr;
    if (take) begin
      next_st.long_subroutine_call_go = 1'b1;
      next_st.vector   = tlic_vector(st.req_idx);
      next_st.svc_idx  = st.req_idx;
      next_st.req      = 1'b0;
      if (st.req_high) begin
        next_st.in_svc_hi = 1'b1;
      end else begin
        next_st.in_svc_lo = 1'b1;
      end
      if (TLIC_AUTO_CLR[st.req_idx]) begin
        clr_mask[st.req_idx] = 1'b1;
      end
    end

    // Return pops the innermost level
    if (cpu_return_from_handler_done) begin
      next_st.req = 1'b0;
      if (st.in_svc_hi) begin
        next_st.in_svc_hi = 1'b0;
      end else begin
        next_st.in_svc_lo = 1'b0;
      end
    end

    // Set beats clear so no event is lost
    set_mask     = src_event;
    next_st.pend = (st.pend & ~clr_mask) | set_mask;

    // Register writes, byte then bit
    if (sfr_wr && sfr_addr == TLIC_IE_ADDR) begin
      next_st.ie = sfr_wdata;
    end
    if (sfr_bit_wr && sfr_bit_addr[7:3] == TLIC_IE_BIT_BASE) begin
      next_st.ie[sfr_bit_addr[2:0]] = sfr_bit_val;
    end

    // Reads return the live register, already cleared after a clear
    if (sfr_rd) begin
      if (sfr_addr == TLIC_IE_ADDR) begin
        next_st.rdata = st.ie;
      end else begin
        next_st.rdata = TLIC_RD_UNMAPPED;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st           <= '0;
      st.ie        <= TLIC_IE_RESET;
      st.pend      <= TLIC_PEND_RESET;
      // Idle level, so no false edge follows reset
      st.pin_s1    <= TLIC_PIN_IDLE;
      st.pin_s2    <= TLIC_PIN_IDLE;
      st.pin_prev  <= TLIC_PIN_IDLE;
      st.vector    <= TLIC_VEC_BASE;
      st.rdata     <= TLIC_RD_UNMAPPED;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign sfr_rdata             = st.rdata;
  assign irq_req               = st.req;
  assign long_subroutine_call  = st.long_subroutine_call_go;
  assign service_handler_addr  = st.vector;
  assign pend_flags            = st.pend;
  assign interrupt_enable_mask = st.ie;

endmodule : tlic_top

// ---- testbench/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, sys_rst, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, run;
  logic        cpu_instr_done, cpu_return_from_handler_done, irq_req, long_subroutine_call;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, sfr_bit_addr, interrupt_enable_mask, ev, en;
  logic [5:0]  aux_enable;
  logic [11:0] src_prio_high, pend_clr, pend_flags;
  logic [15:0] service_handler_addr;
  logic [3:0]  gap;
  logic [1:0]  depth;
  int          n_fail = 0, checks_done = 0, cyc = 0, src;

  tlic_top i_dut (.clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .sfr_bit_addr, .sfr_bit_wr, .sfr_bit_val, .aux_enable, .src_prio_high, .pend_clr,
    .ext_line_zero_pin(~ev[0]), .tmr_zero_overflow(ev[1]), .ext_line_one_pin(~ev[2]),
    .tmr_one_overflow(ev[3]), .serial_port_event(ev[4]), .tmr_two_low_overflow(ev[5]),
    .tmr_two_high_overflow(ev[6]), .aux_event({5'h00, ev[7]}), .cpu_instr_done, .cpu_return_from_handler_done,
    .irq_req, .long_subroutine_call, .service_handler_addr, .pend_flags, .interrupt_enable_mask);
  tlic_core_model i_core (.clk, .sys_rst, .run, .gap, .long_subroutine_call, .cpu_instr_done,
    .cpu_return_from_handler_done, .depth);

  // ==========
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      complete_run();
    end
  end

  // ==========
  // Access tasks
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk_val(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic wr_byte(logic [7:0] a, logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    tick();
    sfr_wr = 1'b0;
  endtask : wr_byte
  task automatic wr_bit(logic [7:0] a, logic v);
    sfr_bit_addr = a;
    sfr_bit_val  = v;
    sfr_bit_wr   = 1'b1;
    tick();
    sfr_bit_wr = 1'b0;
  endtask : wr_bit
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    tick();
    sfr_rd = 1'b0;
    chk_val({8'h00, sfr_rdata}, {8'h00, exp});
  endtask : rd_chk
  // Pins need two sync stages, so the settle time covers them
  task automatic fire(int k);
    ev = 8'h01 << k;
    tick();
    ev = 8'h00;
    tick(3);
  endtask : fire
  task automatic wait_call(logic [15:0] exp);
    int k;
    k = 0;
    tick();
    while (long_subroutine_call !== 1'b1 && k < 100) begin
      tick();
      k++;
    end
    chk_val((long_subroutine_call === 1'b1) ? service_handler_addr : 16'hFFFF, exp);
  endtask : wait_call
  task automatic clear_all();
    pend_clr = 12'hFFF;
    run      = 1'b1;
    tick();
    pend_clr = 12'h000;
    repeat (100) if (depth != 2'h0) tick();
    chk_val(16'(pend_flags), 16'h0000);
  endtask : clear_all
  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // ==========
  // Tests
  initial begin
    {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, run, sfr_addr, sfr_wdata, sfr_bit_addr, ev} = '0;
    {aux_enable, src_prio_high, pend_clr, gap} = '0;
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    rd_chk(8'hA8, 8'h00);
    wr_byte(8'hA9, 8'hFF);
    rd_chk(8'hA9, 8'h00);
    wr_bit(8'hAE, 1'b1);
    rd_chk(8'hA8, 8'h40);
    chk_val(16'(interrupt_enable_mask), 16'h0040);
    // Masked first (gate off or own bit off), then enabled: one call each
    for (int k = 0; k < 8; k++) begin
      src = (k == 6) ? 5 : (k == 7) ? 6 : k;
      en  = (src < 6) ? 8'h01 << src : 8'h00;
      gap = 4'(k);
      wr_byte(8'hA8, k[0] ? 8'hBF & ~en : 8'h7F);
      fire(k);
      chk_val(16'(pend_flags), 16'h0001 << src);
      chk_val(16'(irq_req), 16'h0000);
      wr_byte(8'hA8, 8'h80 | en);
      aux_enable = 6'(src == 6);
      run        = 1'b1;
      wait_call(16'h0003 + 16'(src * 8));
      chk_val(16'(pend_flags), (src < 4) ? 16'h0000 : 16'h0001 << src);
      clear_all();
    end
    // Gate cleared one edge before a boundary: call still taken
    run = 1'b0;
    gap = 4'h0;
    wr_byte(8'hA8, 8'h82);
    fire(1);
    // Core's wait count must run out, else the boundary lands too late
    tick(4);
    run = 1'b1;
    wr_bit(8'hAF, 1'b0);
    wait_call(16'h000B);
    rd_chk(8'hA8, 8'h02);
    clear_all();
    // Clear followed by a two-cycle instruction: no call, flag kept
    run = 1'b0;
    wr_byte(8'hA8, 8'h82);
    fire(1);
    wr_bit(8'hAF, 1'b0);
    run = 1'b1;
    wait_call(16'hFFFF);
    chk_val(16'(pend_flags), 16'h0002);
    clear_all();
    // Low handler holds off low sources; a high one nests; a left flag re-enters
    run           = 1'b0;
    src_prio_high = 12'h002;
    wr_byte(8'hA8, 8'h9A);
    fire(4);
    run = 1'b1;
    wait_call(16'h0023);
    run = 1'b0;
    fire(3);
    chk_val(16'(irq_req), 16'h0000);
    fire(1);
    run = 1'b1;
    wait_call(16'h000B);
    wait_call(16'h001B);
    wait_call(16'h0023);
    clear_all();
    complete_run();
  end
endmodule : tb_top

// ---- testbench/tlic_core_model.sv ----
module tlic_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Pace from the bench
  input  wire logic       run,
  input  wire logic [3:0] gap,
  // Controller side
  input  wire logic       long_subroutine_call,
  output logic            cpu_instr_done,
  output logic            cpu_return_from_handler_done,
  output logic [1:0]      depth
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic [1:0] left;
  // ==========
  // Handler of three instructions, then a return
  always_ff @(posedge clk) begin
    cpu_instr_done <= 1'b0;
    cpu_return_from_handler_done  <= 1'b0;
    if (sys_rst) begin
      cnt   <= 4'h0;
      left  <= 2'h0;
      depth <= 2'h0;
    end else if (long_subroutine_call) begin
      depth <= depth + 2'h1;
      left  <= 2'h3;
      cnt   <= gap;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (run) begin
      cnt <= gap;
      // A return never doubles as a boundary
      if (depth != 2'h0 && left == 2'h0) begin
        cpu_return_from_handler_done <= 1'b1;
        depth         <= depth - 2'h1;
      end else begin
        cpu_instr_done <= 1'b1;
        left           <= left - {1'b0, left != 2'h0};
      end
    end
  end
endmodule : tlic_core_model

// ---- testbench/tlic_sva.sv ----
module tlic_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire logic [7:0]  interrupt_enable_mask,
  // Requests and calls
  input wire logic        serial_port_event,
  input wire logic        cpu_instr_done,
  input wire logic        cpu_return_from_handler_done,
  input wire logic        irq_req,
  input wire logic        long_subroutine_call,
  input wire logic [15:0] service_handler_addr,
  input wire logic [11:0] pend_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Checks
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_call_cause:
    assert property (long_subroutine_call |-> $past(irq_req) && $past(cpu_instr_done)) else $error("call uncaused");
  a_call_pulse:
    assert property (long_subroutine_call |=> !long_subroutine_call) else $error("call too long");
  a_return_from_handler_no_call:
    assert property (cpu_return_from_handler_done |=> !long_subroutine_call) else $error("call on return");
  a_gate_blocks:
    assert property (!$past(interrupt_enable_mask[7]) |-> !irq_req) else $error("gate ignored");
  a_req_has_pend:
    assert property (irq_req |-> $past(pend_flags) != 12'h000) else $error("request without flag");
  a_vector_shape:
    assert property (long_subroutine_call |-> service_handler_addr[2:0] == 3'h3
      && service_handler_addr[15:3] < 13'h00C) else $error("bad handler address");
  a_event_sets:
    assert property (serial_port_event |=> pend_flags[4]) else $error("flag not set");
  a_read_back:
    assert property (sfr_rd && sfr_addr == 8'hA8 |=> sfr_rdata == $past(interrupt_enable_mask))
      else $error("bad read data");
  c_call: cover property (long_subroutine_call);
  // The return edge drops the request, so it comes back one edge later
  c_rereq: cover property (cpu_return_from_handler_done ##2 irq_req);
  c_nest: cover property (long_subroutine_call ##[1:40] long_subroutine_call);
endmodule : tlic_sva

bind tlic_top tlic_sva i_sva (.clk, .sys_rst, .sfr_addr, .sfr_rd, .sfr_rdata, .interrupt_enable_mask,
  .serial_port_event, .cpu_instr_done, .cpu_return_from_handler_done, .irq_req, .long_subroutine_call,
  .service_handler_addr, .pend_flags);
